// ### hdl/firq_regs.sv
// APB register bank: receive mirror, FIFO thresholds, low field level, target ID holder
// Assumes same-clock FIFO status and flags; por, en and the field comparator arrive asynchronously
`timescale 1ns/1ns
`default_nettype none
module firq_regs
   import firq_pkg::*;
(
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [ADDR_W-1:0]     paddr,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   input  wire logic                  por,
   input  wire logic                  en,
   input  wire logic                  rx_start_flag,
   input  wire firq_fifo_stat_t       fifo_stat,
   input  wire firq_id_size_t         id_size,
   input  wire logic                  field_above_collision,
   output logic                       rx_in_progress,
   output logic                       rx_done_irq,
   output logic                       fifo_irq,
   output logic                       clock_extractor_dis,
   output logic      [2:0]            collision_level,
   output logic                       collision_comparator_out,
   output logic      [ID_MAX*8-1:0]   target_identifier
);

   logic [7:0]                fifo_thr;
   logic [7:0]                low_field_level;
   logic [ID_MAX-1:0][7:0]    id_mem;
   logic [3:0]                id_ptr;
   logic [3:0]                id_rd_idx;
   logic                      rx_mirror;
   logic [2:0]                sync1;
   logic [2:0]                sync2;

   // Threshold and length decoders
   function automatic logic [7:0] hi_level(input logic [1:0] code);
      unique case (code)
         2'b00: hi_level = HI_LVL_0;
         2'b01: hi_level = HI_LVL_1;
         2'b10: hi_level = HI_LVL_2;
         2'b11: hi_level = HI_LVL_3;
      endcase
   endfunction

   function automatic logic [7:0] lo_level(input logic [1:0] code);
      unique case (code)
         2'b00: lo_level = LO_LVL_0;
         2'b01: lo_level = LO_LVL_1;
         2'b10: lo_level = LO_LVL_2;
         2'b11: lo_level = LO_LVL_3;
      endcase
   endfunction

   function automatic logic [3:0] id_len(input firq_id_size_t sz);
      unique case ({sz.id_size_hi, sz.id_size_lo})
         2'b00:   id_len = ID_LEN_4;
         2'b01:   id_len = ID_LEN_7;
         2'b10:   id_len = ID_LEN_10;
         default: id_len = 4'h0;
      endcase
   endfunction

   // Bus decode
   wire [ADDR_W-3:0] idx        = paddr[ADDR_W-1:2];
   wire              setup      = psel & ~penable;
   wire              wr_commit  = psel & penable & pready & pwrite;
   wire              hit_mirror = (idx == IDX_RX_MIRROR[ADDR_W-3:0]);
   wire              hit_thr    = (idx == IDX_FIFO_THR[ADDR_W-3:0]);
   wire              hit_low    = (idx == IDX_LOW_FIELD[ADDR_W-3:0]);
   wire              hit_id     = (idx == IDX_TARGET_ID[ADDR_W-3:0]);
   wire              hit_ctrl   = (idx == IDX_ID_CTRL[ADDR_W-3:0]);
   wire              hit_stat   = (idx == IDX_ID_STAT[ADDR_W-3:0]);
   wire              mapped     = hit_mirror | hit_thr | hit_low | hit_id | hit_ctrl | hit_stat;
   wire              ro_hit     = hit_mirror | hit_stat;

   // Power-on clear after two-stage synchronisation
   wire              por_s      = sync2[0];
   wire              en_s       = sync2[1];
   wire              clr        = por_s & ~en_s;

   wire [3:0]        cur_len    = id_len(id_size);
   wire              size_bad   = (cur_len == 4'h0);
   wire              id_wr      = wr_commit & hit_id & (id_ptr < cur_len);
   wire              restart    = wr_commit & hit_ctrl & pwdata[0];
   wire              id_done    = ~size_bad & (id_ptr == cur_len);
   wire [7:0]        id_rd_byte = (id_rd_idx < 4'(ID_MAX)) ? id_mem[id_rd_idx] : 8'h00;

   wire [7:0]        hi_thr     = hi_level(fifo_thr[3:2]);
   wire [7:0]        lo_thr     = lo_level(fifo_thr[1:0]);
   wire              next_fifo_irq = (fifo_stat.rx_active & (fifo_stat.count >= hi_thr)) |
                                     (fifo_stat.tx_active & (fifo_stat.count <= lo_thr));

   logic [7:0]       rd_byte;
   always_comb begin
      rd_byte = 8'h00;
      if (hit_mirror) begin
         rd_byte = {7'h00, rx_mirror};                                           // R1 R14
      end else if (hit_thr) begin
         rd_byte = fifo_thr & MASK_FIFO_THR;                                     // R14
      end else if (hit_low) begin
         rd_byte = low_field_level;
      end else if (hit_id) begin
         rd_byte = id_rd_byte;
      end else if (hit_ctrl) begin
         rd_byte = {id_rd_idx, 4'h0};
      end else if (hit_stat) begin
         rd_byte = {id_ptr, 2'b00, size_bad, id_done};
      end
   end

   wire [31:0]       next_prdata  = setup ? {24'h000000, rd_byte} : 32'h00000000;
   wire              next_pslverr = setup & (~mapped | (pwrite & ro_hit));

   // APB answer: one wait-free access phase after every setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h00000000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         prdata  <= next_prdata;
         pready  <= setup;
         pslverr <= next_pslverr;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1 <= 3'b000;
         sync2 <= 3'b000;
      end else begin
         sync1 <= {field_above_collision, en, por};
         sync2 <= sync1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fifo_thr        <= RST_FIFO_THR;
         low_field_level <= RST_LOW_FIELD;
      end else if (clr) begin
         fifo_thr        <= RST_FIFO_THR;                                        // R5
         low_field_level <= RST_LOW_FIELD;                                       // R5
      end else if (wr_commit) begin
         if (hit_thr) begin
            fifo_thr <= pwdata[7:0] & MASK_FIFO_THR;                             // R3 R4 R14
         end
         if (hit_low) begin
            low_field_level <= pwdata[7:0];                                      // R6 R7
         end
      end
   end

   // Identifier store, filled byte by byte by one continuous write burst
   genvar g;
   generate
      for (g = 0; g < ID_MAX; g++) begin : g_id
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               id_mem[g] <= 8'h00;
            end else if (id_wr && id_ptr == 4'(g)) begin
               id_mem[g] <= pwdata[7:0];                                         // R9
            end
         end
         assign target_identifier[g*8 +: 8] = id_mem[g];
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         id_ptr    <= 4'h0;
         id_rd_idx <= 4'h0;
      end else begin
         if (restart) begin
            id_ptr <= 4'h0;
         end else if (id_wr) begin
            id_ptr <= id_ptr + 4'h1;                                             // R11 R12
         end
         if (wr_commit && hit_ctrl) begin
            id_rd_idx <= pwdata[7:4];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_mirror                <= 1'b0;
         rx_done_irq              <= 1'b0;
         fifo_irq                 <= 1'b0;
         collision_comparator_out <= 1'b0;
      end else begin
         rx_mirror                <= rx_start_flag;                              // R1 R2
         rx_done_irq              <= rx_mirror & ~rx_start_flag;                 // R2
         fifo_irq                 <= next_fifo_irq;                              // R13
         collision_comparator_out <= sync2[2];                                   // R8
      end
   end

   assign rx_in_progress      = rx_mirror;
   assign clock_extractor_dis = low_field_level[POS_CLEX_DIS];                   // R6
   assign collision_level     = low_field_level[2:0];                            // R7

   AST_MIRROR: assert property (@(posedge pclk) disable iff (!presetn) // R1
      rx_start_flag |=> rx_in_progress)
      else $error("mirror bit missed receive-start flag");

   AST_RX_DONE: assert property (@(posedge pclk) disable iff (!presetn) // R2
      $fell(rx_in_progress) |-> rx_done_irq)
      else $error("no completion pulse at end of reception");

   AST_FIFO_HI: assert property (@(posedge pclk) disable iff (!presetn) // R3
      (fifo_stat.rx_active && fifo_thr[3:2] == 2'b01 && fifo_stat.count == 8'h78)
      |=> fifo_irq)
      else $error("receive threshold 120 did not raise interrupt");

   AST_FIFO_LO: assert property (@(posedge pclk) disable iff (!presetn) // R4
      (!fifo_stat.rx_active && fifo_thr[1:0] == 2'b10 && fifo_stat.count == 8'h11)
      |=> !fifo_irq)
      else $error("transmit interrupt above threshold 16");

   AST_CLEAR: assert property (@(posedge pclk) disable iff (!presetn) // R5
      clr |=> (fifo_thr == 8'h00 && low_field_level == 8'h00))
      else $error("registers not cleared at power-on");

   AST_CLEX: assert property (@(posedge pclk) disable iff (!presetn) // R6
      (wr_commit && hit_low && !clr) |=> clock_extractor_dis == $past(pwdata[7]))
      else $error("clock extractor disable not taken from bit 7");

   AST_COLL_LVL: assert property (@(posedge pclk) disable iff (!presetn) // R7
      (wr_commit && hit_low && !clr) |=> collision_level == $past(pwdata[2:0]))
      else $error("collision level not taken from bits 2 to 0");

   AST_COMP: assert property (@(posedge pclk) disable iff (!presetn) // R8
      $rose(field_above_collision) ##1 field_above_collision[*2]
      |=> collision_comparator_out)
      else $error("comparator output not shown after three cycles");

   AST_ID_STORE: assert property (@(posedge pclk) disable iff (!presetn) // R9
      id_wr |=> id_ptr == $past(id_ptr) + 4'h1)
      else $error("identifier pointer did not advance on write");

   AST_ID_SIZE: assert property (@(posedge pclk) disable iff (!presetn) // R12
      ({id_size.id_size_hi, id_size.id_size_lo} == 2'b11) |-> !id_wr && !id_done)
      else $error("forbidden size code accepted an identifier byte");

   AST_RESERVED: assert property (@(posedge pclk) disable iff (!presetn) // R14
      (pready && !pwrite && paddr[ADDR_W-1:2] == IDX_FIFO_THR[ADDR_W-3:0])
      |-> prdata[31:4] == 28'h0000000)
      else $error("reserved threshold bits read non-zero");

   // Further checks: mirror and completion, threshold table against the fixed byte levels, reserved bits and refused ID writes
   AST_MIRROR_LOW: assert property (@(posedge pclk) disable iff (!presetn) // R1
      !rx_start_flag |=> !rx_in_progress)
      else $error("mirror bit set without receive-start flag");

   AST_RX_DONE_SRC: assert property (@(posedge pclk) disable iff (!presetn) // R2
      rx_done_irq |-> ($past(rx_in_progress) && !rx_in_progress))
      else $error("completion pulse without end of reception");

   AST_HI_124: assert property (@(posedge pclk) disable iff (!presetn) // R3
      (fifo_stat.rx_active && fifo_thr[3:2] == 2'b00 && fifo_stat.count >= 8'h7C) |=> fifo_irq)
      else $error("receive threshold 124 did not raise interrupt");

   AST_HI_112: assert property (@(posedge pclk) disable iff (!presetn) // R3
      (fifo_stat.rx_active && fifo_thr[3:2] == 2'b10 && fifo_stat.count >= 8'h70) |=> fifo_irq)
      else $error("receive threshold 112 did not raise interrupt");

   AST_HI_96: assert property (@(posedge pclk) disable iff (!presetn) // R3
      (fifo_stat.rx_active && fifo_thr[3:2] == 2'b11 && fifo_stat.count >= 8'h60) |=> fifo_irq)
      else $error("receive threshold 96 did not raise interrupt");

   AST_HI_BELOW: assert property (@(posedge pclk) disable iff (!presetn) // R3
      (!fifo_stat.tx_active && fifo_thr[3:2] == 2'b00 && fifo_stat.count < 8'h7C) |=> !fifo_irq)
      else $error("receive interrupt below threshold 124");

   AST_LO_4: assert property (@(posedge pclk) disable iff (!presetn) // R4
      (fifo_stat.tx_active && fifo_thr[1:0] == 2'b00 && fifo_stat.count <= 8'h04) |=> fifo_irq)
      else $error("transmit threshold 4 did not raise interrupt");

   AST_LO_8: assert property (@(posedge pclk) disable iff (!presetn) // R4
      (fifo_stat.tx_active && fifo_thr[1:0] == 2'b01 && fifo_stat.count <= 8'h08) |=> fifo_irq)
      else $error("transmit threshold 8 did not raise interrupt");

   AST_LO_32: assert property (@(posedge pclk) disable iff (!presetn) // R4
      (fifo_stat.tx_active && fifo_thr[1:0] == 2'b11 && fifo_stat.count <= 8'h20) |=> fifo_irq)
      else $error("transmit threshold 32 did not raise interrupt");

   AST_LO_ABOVE: assert property (@(posedge pclk) disable iff (!presetn) // R4
      (!fifo_stat.rx_active && fifo_thr[1:0] == 2'b11 && fifo_stat.count > 8'h20) |=> !fifo_irq)
      else $error("transmit interrupt above threshold 32");

   AST_RES_MIRROR: assert property (@(posedge pclk) disable iff (!presetn) // R14
      (pready && !pwrite && paddr[ADDR_W-1:2] == IDX_RX_MIRROR[ADDR_W-3:0])
      |-> prdata[31:1] == 31'h00000000)
      else $error("reserved mirror bits read non-zero");

   AST_ID_IGNORE: assert property (@(posedge pclk) disable iff (!presetn) // R12
      (wr_commit && hit_id && !id_wr) |=> $stable(target_identifier))
      else $error("identifier changed by a refused byte write");

endmodule
`default_nettype wire

// ### hdl/firq_pkg.sv
// Constants, register map and carrier types for the FIFO threshold and field-level register bank
// Assumes an APB master on pclk; register indices are multiplied by four to form byte addresses
// Function
// R1 - Mirror bit 0 copies receive-start flag
// R2 - Mirror shows reception; interrupt on completion
// R3 - Receive threshold codes select 124/120/112/96
// R4 - Transmit threshold codes select 4/8/16/32
// R5 - Power-on with enable low clears registers
// R6 - Bit 7 disables the clock extractor
// R7 - Bits 2..0 select collision field level
// R8 - Comparator output shown as protocol bit 6; code drives it only on the separate collision_comparator_out output
// R9 - Target ID register stores device identifier
// R10 - Host first writes ID size and anticollision
// R11 - Host loads ID in one matching burst
// R12 - Size codes 00/01/10 mean 4/7/10 bytes
// R13 - FIFO interrupt at receive or transmit threshold
// R14 - Reserved bits read zero, ignore writes
package firq_pkg;
   localparam int          ADDR_W        = 8;
   localparam int          ID_MAX        = 10;
   localparam logic [7:0]  IDX_RX_MIRROR = 8'h11;
   localparam logic [7:0]  IDX_FIFO_THR  = 8'h14;
   localparam logic [7:0]  IDX_LOW_FIELD = 8'h16;
   localparam logic [7:0]  IDX_TARGET_ID = 8'h17;
   localparam logic [7:0]  IDX_ID_CTRL   = 8'h1E;
   localparam logic [7:0]  IDX_ID_STAT   = 8'h1F;
   localparam logic [7:0]  RST_FIFO_THR  = 8'h00;
   localparam logic [7:0]  RST_LOW_FIELD = 8'h00;
   localparam logic [7:0]  MASK_FIFO_THR = 8'h0F;
   localparam int          POS_CLEX_DIS  = 7;
   localparam int          POS_PROTO_COL = 6;
   localparam logic [7:0]  HI_LVL_0      = 8'h7C;
   localparam logic [7:0]  HI_LVL_1      = 8'h78;
   localparam logic [7:0]  HI_LVL_2      = 8'h70;
   localparam logic [7:0]  HI_LVL_3      = 8'h60;
   localparam logic [7:0]  LO_LVL_0      = 8'h04;
   localparam logic [7:0]  LO_LVL_1      = 8'h08;
   localparam logic [7:0]  LO_LVL_2      = 8'h10;
   localparam logic [7:0]  LO_LVL_3      = 8'h20;
   localparam logic [3:0]  ID_LEN_4      = 4'h4;
   localparam logic [3:0]  ID_LEN_7      = 4'h7;
   localparam logic [3:0]  ID_LEN_10     = 4'hA;
   localparam int          SYNC_STAGES   = 2;

   typedef struct packed {
      logic       rx_active;
      logic       tx_active;
      logic [7:0] count;
   } firq_fifo_stat_t;

   typedef struct packed {
      logic id_size_hi;
      logic id_size_lo;
   } firq_id_size_t;
endpackage

// ### tb/firq_far_model.sv
// FIFO status source facing the register bank: a byte count that steps toward a level
// Assumes one clock shared with the bank; the count moves one byte per cycle like a real FIFO
`timescale 1ns/1ns
`default_nettype none
module firq_far_model
   import firq_pkg::*;
(
   input  wire logic            pclk,
   input  wire logic            presetn,
   input  wire logic            rx_mode,
   input  wire logic            tx_mode,
   input  wire logic [7:0]      level,
   output var  firq_fifo_stat_t fifo_stat
);
   logic [7:0] count;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= 8'h00;
      end else if (count < level) begin
         count <= count + 8'h01;
      end else if (count > level) begin
         count <= count - 8'h01;
      end
   end

   assign fifo_stat = '{rx_active: rx_mode, tx_active: tx_mode, count: count};
endmodule
`default_nettype wire

// ### tb/fifo_irq_level_field_config_tb.sv
// Self-checking bench for the threshold and field-level register bank over APB
// Assumes the bank answers every transfer one cycle after setup
`timescale 1ns/1ns
`default_nettype none
module fifo_irq_level_field_config_tb
   import firq_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, por, en, rxf, fac, rxm, txm;
   logic [7:0] paddr, lvl, hi[4], lo[4], ln[3];
   logic [31:0] pwdata, prdata, rd;
   logic er, rip, rdi, firq, ced, cco;
   logic [2:0] cl;
   logic [ID_MAX*8-1:0] tid;
   firq_fifo_stat_t fs;
   firq_id_size_t ids;
   int err_count, cmp_count;

   firq_regs u_firq_regs (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .por(por), .en(en), .rx_start_flag(rxf), .fifo_stat(fs),
      .id_size(ids), .field_above_collision(fac), .rx_in_progress(rip), .rx_done_irq(rdi),
      .fifo_irq(firq), .clock_extractor_dis(ced), .collision_level(cl),
      .collision_comparator_out(cco), .target_identifier(tid));
   firq_far_model u_firq_far_model (.pclk(pclk), .presetn(presetn), .rx_mode(rxm),
      .tx_mode(txm), .level(lvl), .fifo_stat(fs));

   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   task report_and_stop;
      if (err_count == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("Error %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task tmo;
      err_count++;
      $display("Error %0t wait ran out", $time);
      report_and_stop();
   endtask

   // One APB transfer; holds the request until pready is sampled high
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
         if (n > 20) tmo();
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Moves the FIFO count to a target level, then lets the registered flag follow
   task settle(input logic [7:0] t);
      int n;
      lvl <= t;
      for (n = 0; fs.count !== t; n++) begin
         if (n > 300) tmo();
         @(posedge pclk);
      end
      repeat (3) @(posedge pclk);
   endtask

   initial begin
      {psel, penable, pwrite, por, rxf, fac, rxm, txm} = '0;
      {paddr, lvl, pwdata} = '0;
      en = 1'b1;
      ids = '0;
      presetn = 1'b0;
      hi = '{HI_LVL_0, HI_LVL_1, HI_LVL_2, HI_LVL_3};
      lo = '{LO_LVL_0, LO_LVL_1, LO_LVL_2, LO_LVL_3};
      ln = '{8'(ID_LEN_4), 8'(ID_LEN_7), 8'(ID_LEN_10)};
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, 8'h50, 0); chk(rd, 0);
      apb(0, 8'h58, 0); chk(rd, 0);
      apb(1, 8'h50, 32'hFF); apb(0, 8'h50, 0); chk(rd, 32'h0F);
      apb(1, 8'h58, 32'h8D); @(posedge pclk); chk({ced, cl}, 4'hD);
      apb(0, 8'h00, 0); chk(er, 1);
      apb(1, 8'h44, 32'hFF); chk(er, 1);
      // Threshold and field-level clear by the power-on pins
      por <= 1'b1; en <= 1'b0;
      repeat (6) @(posedge pclk);
      por <= 1'b0; en <= 1'b1;
      apb(0, 8'h50, 0); chk(rd, 0);
      apb(0, 8'h58, 0); chk(rd, 0);
      rxf <= 1'b1;
      repeat (3) @(posedge pclk);
      chk(rip, 1);
      apb(0, 8'h44, 0); chk(rd, 1);
      rxf <= 1'b0;
      for (int n = 0; rdi !== 1'b1; n++) begin
         if (n > 5) tmo();
         @(posedge pclk);
      end
      chk(rip, 0);
      @(posedge pclk); chk(rdi, 0);
      fac <= 1'b1;
      repeat (5) @(posedge pclk);
      chk(cco, 1);
      for (int c = 0; c < 4; c++) begin
         apb(1, 8'h50, {28'h0, 2'(c), 2'(c)});
         rxm <= 1'b1;
         settle(hi[c] - 8'h01); chk(firq, 0);
         settle(hi[c]); chk(firq, 1);
         rxm <= 1'b0; txm <= 1'b1;
         settle(lo[c] + 8'h01); chk(firq, 0);
         settle(lo[c]); chk(firq, 1);
         txm <= 1'b0;
      end
      for (int s = 0; s < 3; s++) begin
         ids <= firq_id_size_t'(2'(s));
         apb(1, 8'h78, 32'h1);
         for (int k = 0; k <= ln[s]; k++) apb(1, 8'h5C, 32'(16 * s + k + 1));
         for (int k = 0; k < ln[s]; k++) chk(tid[8*k +: 8], 32'(16 * s + k + 1));
         if (s == 0) chk(tid[39:32], 0);
         apb(0, 8'h7C, 0); chk(rd[0], 1);
      end
      apb(1, 8'h78, 32'h20); apb(0, 8'h78, 0); chk(rd, 32'h20);
      apb(0, 8'h5C, 0); chk(rd, 32'h23);
      ids <= firq_id_size_t'(2'b11);
      apb(1, 8'h78, 32'h1); apb(1, 8'h5C, 32'h55);
      apb(0, 8'h7C, 0); chk(rd, 32'h02);
      chk(tid[7:0], 8'h21);
      report_and_stop();
   end
endmodule
`default_nettype wire
